// ===== core/rsbc_map.vh
// constants for the reset, self-test, boot load and clock mode block
`ifndef RSBC_MAP_VH
`define RSBC_MAP_VH
// register byte offsets
`define RSBC_CTRL_OFS     8'h00
`define RSBC_STATUS_OFS   8'h04
`define RSBC_ROMDATA_OFS  8'h08
`define RSBC_BCCFG_OFS    8'h0c
// control register fields
`define RSBC_CTRL_RATIO_LSB  0
`define RSBC_CTRL_RATIO_MSB  1
`define RSBC_CTRL_RST        2'h0
// board cache configuration: write-enable pulse width in cpu cycles
`define RSBC_BCCFG_WE_LSB    0
`define RSBC_BCCFG_WE_MSB    3
`define RSBC_BCCFG_RST       4'h1
// ratio codes and system clock ratios
`define RSBC_RC_3   2'h0
`define RSBC_RC_4   2'h1
`define RSBC_RC_15  2'h2
`define RSBC_RATIO_3   4'h3
`define RSBC_RATIO_4   4'h4
`define RSBC_RATIO_15  4'hf
// self-test end, cpu cycles from first system clock edge
`define RSBC_BUILT_IN_SELF_TEST_R3    24'd67935
`define RSBC_BUILT_IN_SELF_TEST_R4    24'd78888
`define RSBC_BUILT_IN_SELF_TEST_R15   24'd199380
// boot rom load end, cpu cycles
`define RSBC_ROM_R3     24'd13224651
`define RSBC_ROM_R4     24'd13224776
`define RSBC_ROM_R15    24'd13224780
// boot rom clock period and its halves, cpu cycles
`define RSBC_ROM_PER    7'd126
`define RSBC_ROM_HALF   7'd63
// clock mode encodings
`define RSBC_CM_DIV2    2'h0
`define RSBC_CM_DIV1    2'h1
`define RSBC_CM_DIV4    2'h2
`define RSBC_CM_CKRST   2'h3
// fifo shape
`define RSBC_FIFO_W     8
`define RSBC_FIFO_D     8
`endif

// ===== core/rsbc_seq.v
// reset sequencer with self-test, boot rom load and clock modes
`timescale 1ns/1ns
`include "rsbc_map.vh"

// small fifo holding assembled boot rom bytes
module rsbc_fifo
#(
   parameter W = 8,
   parameter D = 8,
   parameter A = 3
)
(
   // clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // fill side
   input  wire         in_valid_i,
   output wire         in_ready_o,
   input  wire [W-1:0] in_data_i,
   // drain side
   output wire         out_valid_o,
   input  wire         out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg [W-1:0] mem_r [0:D-1];
   reg [A-1:0] wp_r;
   reg [A-1:0] rp_r;
   reg [A:0]   cnt_r;
   wire        push;
   wire        pop;

   // flags from the fill count
   assign in_ready_o  = (cnt_r != D);
   assign out_valid_o = (cnt_r != 0);
   assign out_data_o  = mem_r[rp_r];
   assign push = in_valid_i & in_ready_o;
   assign pop  = out_valid_o & out_ready_i;

   // pointers and count
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wp_r  <= {A{1'b0}};
         rp_r  <= {A{1'b0}};
         cnt_r <= {(A+1){1'b0}};
      end
      else
      begin
         if (push)
            wp_r <= (wp_r == D-1) ? {A{1'b0}} : wp_r + 1'b1;
         if (pop)
            rp_r <= (rp_r == D-1) ? {A{1'b0}} : rp_r + 1'b1;
         if (push & ~pop)
            cnt_r <= cnt_r + 1'b1;
         else if (pop & ~push)
            cnt_r <= cnt_r - 1'b1;
      end
   end

   // storage, one generate entry per word
   genvar g;
   generate
      for (g = 0; g < D; g = g + 1)
      begin : g_ent
         always @(posedge clk_i)
         begin
            if (push && wp_r == g)
               mem_r[g] <= in_data_i;
         end
      end
   endgenerate
endmodule // rsbc_fifo

// top: sequencer, clock modes, cache write pulses, wishbone slave
module rsbc_seq
#(
   parameter [23:0] BUILT_IN_SELF_TEST_R3  = `RSBC_BUILT_IN_SELF_TEST_R3,
   parameter [23:0] BUILT_IN_SELF_TEST_R4  = `RSBC_BUILT_IN_SELF_TEST_R4,
   parameter [23:0] BUILT_IN_SELF_TEST_R15 = `RSBC_BUILT_IN_SELF_TEST_R15,
   parameter [23:0] ROM_R3   = `RSBC_ROM_R3,
   parameter [23:0] ROM_R4   = `RSBC_ROM_R4,
   parameter [23:0] ROM_R15  = `RSBC_ROM_R15
)
(
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   // asynchronous board pins
   input  wire        ext_reset_n_i,
   input  wire        power_good_input_i,
   input  wire [1:0]  clk_mode_i,
   input  wire        ref_clk_i,
   // boot rom
   input  wire        rom_present_n_i,
   input  wire        rom_data_i,
   output reg         rom_clk_o,
   output reg         rom_oe_n_o,
   // sequencer and clock outputs
   output reg         int_reset_o,
   output reg         osc_en_o,
   output reg         sys_en_o,
   output reg         system_clock_output_pair_h_o,
   output reg         system_clock_output_pair_l_o,
   // board cache write enables
   input  wire        bc_write_i,
   output reg         data_ram_we_o,
   output reg         tag_ram_we_o
);
   // sequencer states
   localparam [2:0] S_RST  = 3'd0;
   localparam [2:0] S_EDGE = 3'd1;
   localparam [2:0] S_BUILT_IN_SELF_TEST = 3'd2;
   localparam [2:0] S_ROM  = 3'd3;
   localparam [2:0] S_DONE = 3'd4;

   reg  [6:0]  s1_r;
   reg  [6:0]  s2_r;
   wire        ext_rst_n;
   wire        pgood;
   wire [1:0]  cmode;
   wire        ref_s;
   wire        rom_pres_n;
   wire        rom_bit;
   reg         ref_d_r;
   reg  [1:0]  ratio_sel_r;
   reg  [3:0]  we_width_r;
   reg  [3:0]  ratio;
   reg  [23:0] built_in_self_test_end;
   reg  [23:0] rom_end;
   reg  [3:0]  sdiv_r;
   reg  [1:0]  odiv_r;
   reg  [2:0]  st_r;
   reg  [2:0]  st_nxt;
   reg  [23:0] cnt_r;
   reg  [6:0]  rcnt_r;
   reg  [7:0]  shf_r;
   reg  [2:0]  bits_r;
   reg         push_r;
   reg  [3:0]  we_cnt_r;
   wire        f_ready;
   wire        f_valid;
   wire [7:0]  f_data;
   wire        f_pop;
   wire        stall;
   wire        req;

   // two-flop synchroniser for every asynchronous pin
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_r <= 7'h00;
         s2_r <= 7'h00;
      end
      else
      begin
         s1_r <= {rom_data_i, rom_present_n_i, ref_clk_i,
                  clk_mode_i, power_good_input_i, ext_reset_n_i};
         s2_r <= s1_r;
      end
   end
   assign ext_rst_n  = s2_r[0];
   assign pgood      = s2_r[1];
   assign cmode      = s2_r[3:2];
   assign ref_s      = s2_r[4];
   assign rom_pres_n = s2_r[5];
   assign rom_bit    = s2_r[6];

   // ratio and end counts from the selected ratio code
   always @*
   begin
      case (ratio_sel_r)
         `RSBC_RC_4:
         begin
            ratio    = `RSBC_RATIO_4;
            built_in_self_test_end = BUILT_IN_SELF_TEST_R4;
            rom_end  = ROM_R4;
         end
         `RSBC_RC_15:
         begin
            ratio    = `RSBC_RATIO_15;
            built_in_self_test_end = BUILT_IN_SELF_TEST_R15;
            rom_end  = ROM_R15;
         end
         default:
         begin
            ratio    = `RSBC_RATIO_3;
            built_in_self_test_end = BUILT_IN_SELF_TEST_R3;
            rom_end  = ROM_R3;
         end
      endcase
   end

   // oscillator divider: internal clock enable per clock mode
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         odiv_r   <= 2'h0;
         osc_en_o <= 1'b0;
      end
      else
      begin
         odiv_r <= odiv_r + 1'b1;
         case (cmode)
            `RSBC_CM_DIV1: osc_en_o <= 1'b1;
            `RSBC_CM_DIV4: osc_en_o <= (odiv_r == 2'h3);
            `RSBC_CM_DIV2: osc_en_o <= odiv_r[0];
            default:       osc_en_o <= odiv_r[0];
         endcase
      end
   end

   // system clock generator, realigned to the reference edge in divide-by-four mode
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ref_d_r  <= 1'b0;
         sdiv_r   <= 4'h0;
         sys_en_o <= 1'b0;
         system_clock_output_pair_h_o <= 1'b0;
         system_clock_output_pair_l_o <= 1'b1;
      end
      else
      begin
         ref_d_r <= ref_s;
         if (cmode == `RSBC_CM_CKRST)
         begin
            // held in a known state for tester alignment
            sdiv_r   <= 4'h0;
            sys_en_o <= 1'b0;
            system_clock_output_pair_h_o <= 1'b0;
            system_clock_output_pair_l_o <= 1'b1;
         end
         else
         begin
            if (cmode == `RSBC_CM_DIV4 && ref_s && !ref_d_r)
               sdiv_r <= 4'h1;
            else if (sdiv_r == ratio - 4'h1)
               sdiv_r <= 4'h0;
            else
               sdiv_r <= sdiv_r + 4'h1;
            sys_en_o <= (sdiv_r == ratio - 4'h1);
            system_clock_output_pair_h_o <= (sdiv_r < {1'b0, ratio[3:1]});
            system_clock_output_pair_l_o <= ~(sdiv_r < {1'b0, ratio[3:1]});
         end
      end
   end

   // the load stalls in the cycle a byte is pushed and while the byte fifo is full
   assign stall = push_r | ~f_ready;

   // sequencer next state
   always @*
   begin
      st_nxt = st_r;
      case (st_r)
         S_RST:
            if (ext_rst_n && pgood)
               st_nxt = S_EDGE;
         S_EDGE:
            if (sys_en_o)
               st_nxt = S_BUILT_IN_SELF_TEST;
         S_BUILT_IN_SELF_TEST:
            if (cnt_r == built_in_self_test_end)
               st_nxt = rom_pres_n ? S_DONE : S_ROM;
         S_ROM:
            if (cnt_r == rom_end)
               st_nxt = S_DONE;
         S_DONE:
            st_nxt = S_DONE;
         default:
            st_nxt = S_RST;
      endcase
      if (!ext_rst_n || !pgood)
         st_nxt = S_RST;
   end

   // sequencer, cycle counter and boot rom shifter
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r        <= S_RST;
         cnt_r       <= 24'h000000;
         rcnt_r      <= 7'h00;
         shf_r       <= 8'h00;
         bits_r      <= 3'h0;
         push_r      <= 1'b0;
         int_reset_o <= 1'b1;
         rom_clk_o   <= 1'b0;
         rom_oe_n_o  <= 1'b1;
      end
      else
      begin
         st_r   <= st_nxt;
         push_r <= 1'b0;
         // internal reset drops only in the done state
         int_reset_o <= (st_nxt != S_DONE);
         rom_oe_n_o  <= (st_nxt != S_ROM);
         if (st_r == S_EDGE)
            cnt_r <= 24'h000001;
         else if (st_r == S_BUILT_IN_SELF_TEST)
            cnt_r <= cnt_r + 24'h000001;
         else if (st_r == S_ROM && !stall)
            cnt_r <= cnt_r + 24'h000001;
         else if (st_r == S_RST)
            cnt_r <= 24'h000000;
         if (st_r != S_ROM)
         begin
            rcnt_r    <= 7'h00;
            bits_r    <= 3'h0;
            rom_clk_o <= 1'b0;
         end
         else if (!stall)
         begin
            // period of 126 unstalled cycles, stretched by stalls, never shortened
            if (rcnt_r == `RSBC_ROM_PER - 7'd1)
               rcnt_r <= 7'h00;
            else
               rcnt_r <= rcnt_r + 7'h01;
            rom_clk_o <= (rcnt_r == `RSBC_ROM_HALF - 7'd1) ? 1'b1 :
                         (rcnt_r == `RSBC_ROM_PER - 7'd1) ? 1'b0 :
                         rom_clk_o;
            // late sample leaves the rom its full data delay
            if (rcnt_r == `RSBC_ROM_PER - 7'd1)
            begin
               shf_r  <= {rom_bit, shf_r[7:1]};
               bits_r <= bits_r + 3'h1;
               if (bits_r == 3'h7)
                  push_r <= 1'b1;
            end
         end
      end
   end

   // byte buffer between rom load and software
   rsbc_fifo
   #(
      .W (`RSBC_FIFO_W),
      .D (`RSBC_FIFO_D),
      .A (3)
   )
   u_fifo
   (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (push_r),
      .in_ready_o  (f_ready),
      .in_data_i   (shf_r),
      .out_valid_o (f_valid),
      .out_ready_i (f_pop),
      .out_data_o  (f_data)
   );

   // board cache write-enable pulses on the cpu clock
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         we_cnt_r      <= 4'h0;
         data_ram_we_o <= 1'b0;
         tag_ram_we_o  <= 1'b0;
      end
      else
      begin
         if (bc_write_i && we_cnt_r == 4'h0 && we_width_r != 4'h0)
            we_cnt_r <= we_width_r;
         else if (we_cnt_r != 4'h0)
            we_cnt_r <= we_cnt_r - 4'h1;
         data_ram_we_o <= (we_cnt_r > 4'h1) ||
                          (bc_write_i && we_cnt_r == 4'h0 &&
                           we_width_r != 4'h0);
         tag_ram_we_o  <= (we_cnt_r > 4'h1) ||
                          (bc_write_i && we_cnt_r == 4'h0 &&
                           we_width_r != 4'h0);
      end
   end

   // wishbone: ack one cycle after request, then one idle cycle
   assign req   = cyc_i & stb_i & ~ack_o;
   assign f_pop = req & ~we_i & (adr_i == `RSBC_ROMDATA_OFS) & f_valid;

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o       <= 1'b0;
         dat_o       <= 32'h00000000;
         ratio_sel_r <= `RSBC_CTRL_RST;
         we_width_r  <= `RSBC_BCCFG_RST;
      end
      else
      begin
         ack_o <= req;
         if (req && we_i && sel_i[0])
         begin
            if (adr_i == `RSBC_CTRL_OFS)
               ratio_sel_r <=
                  dat_i[`RSBC_CTRL_RATIO_MSB:`RSBC_CTRL_RATIO_LSB];
            if (adr_i == `RSBC_BCCFG_OFS)
               we_width_r <= dat_i[`RSBC_BCCFG_WE_MSB:`RSBC_BCCFG_WE_LSB];
         end
         if (req && !we_i)
         begin
            case (adr_i)
               `RSBC_CTRL_OFS:
                  dat_o <= {30'h00000000, ratio_sel_r};
               `RSBC_STATUS_OFS:
                  dat_o <= {22'h000000, f_valid, ~f_ready, cmode,
                            rom_oe_n_o, int_reset_o, 1'b0, st_r};
               `RSBC_ROMDATA_OFS:
                  dat_o <= {23'h000000, f_valid, f_data};
               `RSBC_BCCFG_OFS:
                  dat_o <= {28'h0000000, we_width_r};
               default:
                  dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // rsbc_seq

// ===== verification/rsbc_rom_model.sv
// boot rom model: shifts a fixed byte out lsb first
`timescale 1ns/1ns
module rsbc_rom_model
#(
   parameter [7:0] PAT = 8'ha5
)
(
   input  wire clk_i,
   input  wire rom_clk_i,
   input  wire rom_oe_n_i,
   output wire rom_data_o
);
   reg       ck_r = 1'b0;
   reg       bit_r = 1'b0;
   reg       junk_r = 1'b0;
   reg [2:0] idx_r = 3'h0;
   // new bit one cycle after each rising rom clock, well inside setup
   always @(posedge clk_i)
   begin
      ck_r <= rom_clk_i;
      junk_r <= ~junk_r;
      if (rom_oe_n_i)
         idx_r <= 3'h0;
      else if (rom_clk_i && !ck_r)
      begin
         bit_r <= PAT[idx_r];
         idx_r <= idx_r + 3'h1;
      end
   end
   // not enabled: the line wanders every cycle
   assign rom_data_o = rom_oe_n_i ? junk_r : bit_r;
endmodule // rsbc_rom_model

// ===== verification/rsbc_seq_monitor.sv
// port checker for the reset sequencer, bound to its top
`timescale 1ns/1ns
module rsbc_seq_monitor
(
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire ack_o,
   input wire rom_clk_o,
   input wire rom_oe_n_o,
   input wire int_reset_o,
   input wire system_clock_output_pair_h_o,
   input wire system_clock_output_pair_l_o,
   input wire bc_write_i,
   input wire data_ram_we_o,
   input wire tag_ram_we_o
);
   reg       rc_r;
   reg [7:0] per_r;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // cycles since the last rising rom clock, saturating
   always @(posedge clk_i)
   begin
      rc_r <= rom_clk_o;
      if (rst_i)
         per_r <= 8'h00;
      else if (rom_clk_o && !rc_r)
         per_r <= 8'h01;
      else if (per_r != 8'h00 && per_r != 8'hff)
         per_r <= per_r + 8'h01;
   end
   a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("no ack after request");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without request");
   a_load_reset: assert property (!rom_oe_n_o |-> int_reset_o)
      else $error("internal reset released during load");
   a_release_done: assert property ($fell(int_reset_o) |-> rom_oe_n_o)
      else $error("reset released with rom enabled");
   a_clk_in_load: assert property ($rose(rom_clk_o) |-> !rom_oe_n_o)
      else $error("rom clock outside load");
   a_romclk_min: assert property ($rose(rom_clk_o) && per_r != 8'h00
      |-> per_r >= 8'd111)
      else $error("rom clock period too short");
   a_we_cause: assert property ($rose(data_ram_we_o) |-> $past(bc_write_i))
      else $error("write enable without request");
   a_we_pair: assert property (data_ram_we_o == tag_ram_we_o)
      else $error("write enables differ");
   a_pair_compl: assert property (system_clock_output_pair_l_o
      == !system_clock_output_pair_h_o)
      else $error("clock pair not complementary");
   c_release: cover property ($fell(int_reset_o));
   c_load: cover property ($fell(rom_oe_n_o));
   c_we: cover property ($rose(data_ram_we_o));
endmodule // rsbc_seq_monitor
bind rsbc_seq rsbc_seq_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .rom_clk_o(rom_clk_o),
   .rom_oe_n_o(rom_oe_n_o), .int_reset_o(int_reset_o),
   .system_clock_output_pair_h_o(system_clock_output_pair_h_o),
   .system_clock_output_pair_l_o(system_clock_output_pair_l_o),
   .bc_write_i(bc_write_i), .data_ram_we_o(data_ram_we_o),
   .tag_ram_we_o(tag_ram_we_o));

// ===== verification/rsbc_seq_test.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ns
`include "rsbc_map.vh"
module rsbc_seq_test;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         cyc = 1'b0, stb = 1'b0, we = 1'b0, ext_n = 1'b0;
   reg         pg = 1'b1, rp_n = 1'b1, bcw = 1'b0, win = 1'b0, refc = 1'b0;
   reg  [7:0]  adr = 8'h00;
   reg  [3:0]  sel = 4'h0;
   reg  [31:0] dat = 32'h0, q;
   reg  [1:0]  mode = 2'h0;
   wire [31:0] dat_o;
   wire        ack, rd, rck, roe_n, irst, osc, sys, ph, pl, dwe, twe;
   integer     fail_count = 0, checked = 0, k, t0, n_osc, n_sys, n_ph, n_we;
   always #5 clk_i = ~clk_i;
   // only ratio 3 runs a sequence, so only its end counts are shortened
   rsbc_seq #(.BUILT_IN_SELF_TEST_R3(24'd200), .ROM_R3(24'd4000)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
      .ext_reset_n_i(ext_n), .power_good_input_i(pg), .clk_mode_i(mode),
      .ref_clk_i(refc), .rom_present_n_i(rp_n), .rom_data_i(rd),
      .rom_clk_o(rck), .rom_oe_n_o(roe_n), .int_reset_o(irst),
      .osc_en_o(osc), .sys_en_o(sys), .system_clock_output_pair_h_o(ph),
      .system_clock_output_pair_l_o(pl), .bc_write_i(bcw),
      .data_ram_we_o(dwe), .tag_ram_we_o(twe));
   rsbc_rom_model rom (.clk_i(clk_i), .rom_clk_i(rck), .rom_oe_n_i(roe_n),
      .rom_data_o(rd));
   // event counters over a window
   always @(posedge clk_i)
      if (win)
      begin
         n_osc = n_osc + osc;
         n_sys = n_sys + sys;
         n_ph = n_ph + ph;
         n_we = n_we + dwe;
      end
   task chk(input c, input [127:0] m);
   begin
      checked = checked + 1;
      // an unknown result counts as a mismatch
      if (c !== 1'b1)
      begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED at %0t: %0s", $time, m);
      end
   end
   endtask
   task wb(input [7:0] a, input w, input [3:0] s, input [31:0] d);
      integer n;
   begin
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat <= d;
      n = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20)
      begin
         n = n + 1;
         @(posedge clk_i);
      end
      q = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      chk(n < 20, "no ack");
   end
   endtask
   task count(input integer n);
   begin
      n_osc = 0; n_sys = 0; n_ph = 0; n_we = 0;
      @(posedge clk_i) win <= 1'b1;
      repeat (n) @(posedge clk_i);
      win <= 1'b0;
      @(posedge clk_i);
   end
   endtask
   // cycles until internal reset (w=0) or rom enable (w=1) goes low
   task wait_lo(input integer w);
   begin
      t0 = 0;
      while (((w == 0) ? irst : roe_n) !== 1'b0 && t0 < 20000)
      begin
         @(posedge clk_i);
         t0 = t0 + 1;
      end
   end
   endtask
   task t_regs;
   begin
      wb(`RSBC_CTRL_OFS, 0, 4'hf, 0); chk(q === 32'h0, "ctrl reset");
      wb(`RSBC_BCCFG_OFS, 0, 4'hf, 0); chk(q === 32'h1, "bccfg");
      wb(8'h10, 1, 4'hf, 32'hff);
      wb(8'h10, 0, 4'hf, 0); chk(q === 32'h0, "unmapped");
      wb(`RSBC_BCCFG_OFS, 1, 4'he, 32'h7);
      wb(`RSBC_BCCFG_OFS, 0, 4'hf, 0); chk(q === 32'h1, "sel gate");
   end
   endtask
   task t_noboot;
   begin
      @(posedge clk_i) ext_n <= 1'b1;
      wait_lo(0); chk(t0 >= 200 && t0 <= 240, "built_in_self_test end");
      wb(`RSBC_STATUS_OFS, 0, 4'hf, 0);
      chk(q[2:0] === 3'h4 && q[5:4] === 2'h2, "no rom done");
   end
   endtask
   task t_ratio;
   begin
      for (k = 0; k < 3; k = k + 1)
      begin
         wb(`RSBC_CTRL_OFS, 1, 4'hf, k);
         count(60); chk(n_sys == (k == 0 ? 20 : k == 1 ? 15 : 4), "ratio");
      end
      wb(`RSBC_CTRL_OFS, 1, 4'hf, 0);
   end
   endtask
   task t_modes;
   begin
      for (k = 0; k < 4; k = k + 1)
      begin
         @(posedge clk_i) mode <= k;
         repeat (6) @(posedge clk_i);
         count(24); chk(n_osc == (k == 1 ? 24 : k == 2 ? 6 : 12), "mode");
         if (k == 3) chk(n_ph == 0, "gen held");
      end
      @(posedge clk_i) mode <= 2'h0;
   end
   endtask
   // divide-by-four: a reference rising edge realigns the system clock
   // phase, so the pulse lands a fixed distance after it; the gap
   // between tries varies so a free-running phase cannot match by luck
   task t_align;
   begin
      @(posedge clk_i) mode <= `RSBC_CM_DIV4;
      for (k = 0; k < 3; k = k + 1)
      begin
         repeat (6 + k) @(posedge clk_i);
         refc <= 1'b1;
         repeat (5) @(posedge clk_i);
         chk(sys === 1'b0, "align early");
         @(posedge clk_i);
         chk(sys === 1'b1, "align edge");
         refc <= 1'b0;
      end
      @(posedge clk_i) mode <= `RSBC_CM_DIV2;
   end
   endtask
   task pulse_we(input [3:0] w);
   begin
      wb(`RSBC_BCCFG_OFS, 1, 4'h1, w);
      n_we = 0;
      @(posedge clk_i);
      bcw <= 1'b1; win <= 1'b1;
      @(posedge clk_i) bcw <= 1'b0;
      repeat (20) @(posedge clk_i);
      win <= 1'b0;
      @(posedge clk_i); chk(n_we == w, "we width");
   end
   endtask
   task t_boot;
   begin
      @(posedge clk_i);
      pg <= 1'b0; rp_n <= 1'b0;
      repeat (4) @(posedge clk_i); chk(irst === 1'b1, "pg drop");
      pg <= 1'b1;
      wait_lo(1); chk(t0 >= 200 && t0 <= 240, "load start");
      k = t0;
      wait_lo(0); chk(k + t0 >= 4000 && k + t0 <= 4060, "load end");
      chk(roe_n === 1'b1, "oe after");
      wb(`RSBC_ROMDATA_OFS, 0, 4'hf, 0); chk(q === 32'h1a5, "rom byte");
   end
   endtask
   task print_verdict;
   begin
      if (fail_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_noboot;
      t_ratio;
      t_modes;
      t_align;
      pulse_we(4'h3);
      pulse_we(4'h0);
      t_boot;
      print_verdict;
   end
   initial
   begin
      #300000;
      fail_count = fail_count + 1;
      print_verdict;
   end
endmodule // rsbc_seq_test
